// ===== rtl/dpbr_ram.sv
`timescale 1ns/10ps
module dpbr_ram #(
  parameter int unsigned WIDTH_A = 36,
  parameter int unsigned WIDTH_B = 9
) (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Port A.
  input  wire logic                          enA,
  input  wire logic                          weA,
  input  wire logic [dpbr_pkg::ADDR_BITS-1:0] addrA,
  input  wire logic [WIDTH_A-1:0]            dinA,
  output logic      [WIDTH_A-1:0]            doutA_r,
  // Port B.
  input  wire logic                          enB,
  input  wire logic                          weB,
  input  wire logic [dpbr_pkg::ADDR_BITS-1:0] addrB,
  input  wire logic [WIDTH_B-1:0]            dinB,
  output logic      [WIDTH_B-1:0]            doutB_r
);

  // Each storage line holds four bytes in the low bits and their four
  // parity bits above them.
  logic [dpbr_pkg::LINE_BITS-1:0] mem [dpbr_pkg::LINE_COUNT];

  logic [WIDTH_A-1:0]                doutA_nxt;
  logic [WIDTH_B-1:0]                doutB_nxt;
  logic [dpbr_pkg::LINE_ABITS-1:0]   lineA;
  logic [dpbr_pkg::LINE_ABITS-1:0]   lineB;
  logic [dpbr_pkg::BIT_ABITS-1:0]    slotA;
  logic [dpbr_pkg::BIT_ABITS-1:0]    slotB;

  function automatic logic isParity(input int unsigned w);
    return (w % dpbr_pkg::PAR_UNIT) == 0; // see [R01]
  endfunction

  // Narrow ports see only the data bits of a line, so fewer words fit.
  function automatic int unsigned perLine(input int unsigned w);
    return isParity(w) ? dpbr_pkg::LINE_BITS / w   // see [R07]
                       : dpbr_pkg::DATA_BITS / w;  // see [R08]
  endfunction

  function automatic logic [dpbr_pkg::LINE_ABITS-1:0] lineOf(
    input int unsigned w, input logic [dpbr_pkg::ADDR_BITS-1:0] a);
    return dpbr_pkg::LINE_ABITS'((int'(a) / perLine(w))
                                 % dpbr_pkg::LINE_COUNT);
  endfunction

  function automatic logic [dpbr_pkg::BIT_ABITS-1:0] slotOf(
    input int unsigned w, input logic [dpbr_pkg::ADDR_BITS-1:0] a);
    return dpbr_pkg::BIT_ABITS'(int'(a) % perLine(w));
  endfunction

  // Port bit j of word slot s to a line bit; data low, parity high.
  function automatic logic [dpbr_pkg::BIT_ABITS-1:0] mapBit(
    input int unsigned w, input int unsigned s, input int unsigned j);
    int unsigned k;
    int unsigned dw;
    k  = w / dpbr_pkg::PAR_UNIT;
    dw = k * dpbr_pkg::BYTE_BITS;
    if (!isParity(w)) begin
      return dpbr_pkg::BIT_ABITS'(w * s + j); // see [R10]
    end
    if (j < dw) begin
      return dpbr_pkg::BIT_ABITS'(dw * s + j);
    end
    return dpbr_pkg::BIT_ABITS'(dpbr_pkg::DATA_BITS + k * s + (j - dw)); // see [R02]
  endfunction

  always_comb begin
    lineA = lineOf(WIDTH_A, addrA); // see [R06]
    lineB = lineOf(WIDTH_B, addrB); // see [R06]
    slotA = slotOf(WIDTH_A, addrA);
    slotB = slotOf(WIDTH_B, addrB);
  end

  // Reads return the line content before this edge's writes.
  always_comb begin
    doutA_nxt = doutA_r;
    doutB_nxt = doutB_r;
    if (enA) begin
      for (int unsigned j = 0; j < WIDTH_A; j++) begin
        doutA_nxt[j] = mem[lineA][mapBit(WIDTH_A, slotA, j)]; // see [R11]
      end
    end
    if (enB) begin
      for (int unsigned j = 0; j < WIDTH_B; j++) begin
        doutB_nxt[j] = mem[lineB][mapBit(WIDTH_B, slotB, j)]; // see [R09]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      doutA_r <= '0;
      doutB_r <= '0;
    end else begin
      doutA_r <= doutA_nxt; // see [R03]
      doutB_r <= doutB_nxt; // see [R05]
    end
  end

  // Both ports write one shared array; on the same bit port B wins.
  always_ff @(posedge clk) begin
    if (enA && weA) begin
      for (int unsigned j = 0; j < WIDTH_A; j++) begin
        mem[lineA][mapBit(WIDTH_A, slotA, j)] <= dinA[j]; // see [R04]
      end
    end
    if (enB && weB) begin
      for (int unsigned j = 0; j < WIDTH_B; j++) begin
        mem[lineB][mapBit(WIDTH_B, slotB, j)] <= dinB[j]; // see [R04]
      end
    end
  end

endmodule

// ===== rtl/dpbr_pkg.sv
// Notes on behaviour
// [R01] Parity widths 9, 18, 36 add one bit per byte.
// [R02] Parity bits stored and timed like data.
// [R03] Each port writes and reads one width.
// [R04] Both ports share one 18 Kb array.
// [R05] Each port has own enable, write, address.
// [R06] Port widths chosen separately for width conversion.
// [R07] Parity widths on both ports reach all 18 Kb.
// [R08] Narrow widths reach only 16 Kb data part.
// [R09] Mixed: wide reaches 18 Kb, narrow 16 Kb.
// [R10] Low narrow addresses map to low bits.
// [R11] Read word appears after sampling clock edge.
package dpbr_pkg;
  localparam int unsigned LINE_COUNT = 512;
  localparam int unsigned LINE_BITS  = 36;
  localparam int unsigned DATA_BITS  = 32;
  localparam int unsigned ADDR_BITS  = 14;
  localparam int unsigned LINE_ABITS = 9;
  localparam int unsigned BIT_ABITS  = 6;
  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned PAR_UNIT   = 9;
endpackage

// ===== bench/dpbr_ram_asserts.sv
`timescale 1ns/10ps
module dpbr_ram_asserts #(parameter int unsigned WIDTH_A = 36) (
  input wire logic clk, rst, enA, weA, enB, weB,
  input wire logic [13:0] addrA,
  input wire logic [WIDTH_A-1:0] dinA, doutA_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rst_clear_a: assert property (disable iff (1'b0)
    rst |=> doutA_r == '0) else $error("A not cleared");
  idle_hold_a: assert property (!enA |=> $stable(doutA_r))
    else $error("A moved idle");
  write_read_a: assert property (enA && weA && !(enB && weB) ##1
    enA && !weA && $stable(addrA) |=> doutA_r == $past(dinA, 2))
    else $error("A readback");
  cover property (enA && weA ##1 enA);
  cover property (enB && !weB);
  cover property (enB && weB);
endmodule
bind dpbr_ram dpbr_ram_asserts #(.WIDTH_A(WIDTH_A)) dpbr_ram_asserts_inst (
  .clk(clk), .rst(rst), .enA(enA), .weA(weA), .enB(enB), .weB(weB),
  .addrA(addrA), .dinA(dinA), .doutA_r(doutA_r));

// ===== bench/dpbr_fab.sv
`timescale 1ns/10ps
module dpbr_fab (
  // Port B drive.
  output logic        enB = 0, weB = 0,
  output logic [13:0] addrB = '0,
  output logic [8:0]  dinB = '0
);
  task automatic set(input logic [24:0] v);
    {enB, weB, addrB, dinB} <= v;
  endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct {logic b, w; logic [13:0] a; logic [35:0] d;} dpbr_row_t;
  logic        clk = 0, rst = 1, enA = 0, weA = 0, enB, weB;
  logic [13:0] addrA = '0, addrB;
  logic [35:0] dinA = '0, doutA_r;
  logic [8:0]  dinB, doutB_r;
  int          num_errors = 0, compares = 0;
  dpbr_row_t r [6] = '{'{0, 1, 0, 36'h9_1234_5678}, '{0, 1, 1, 36'h0},
    '{1, 0, 0, 36'h178}, '{1, 0, 3, 36'h112}, '{1, 1, 5, 36'h1ab},
    '{0, 0, 1, 36'h2_0000_ab00}};
  always #10 clk = ~clk;
  dpbr_fab dpbr_fab_inst (.enB(enB), .weB(weB), .addrB(addrB), .dinB(dinB));
  dpbr_ram dpbr_ram_inst (.clk(clk), .rst(rst), .enA(enA), .weA(weA),
    .addrA(addrA), .dinA(dinA), .doutA_r(doutA_r), .enB(enB), .weB(weB),
    .addrB(addrB), .dinB(dinB), .doutB_r(doutB_r));
  task automatic chk(logic [35:0] e, g);
    compares++;
    if (g !== e) num_errors++;
    if (g !== e) $display("mismatch dout expected %h seen %h", e, g);
  endtask
  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #8000 num_errors++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    foreach (r[i]) begin
      @(posedge clk) if (r[i].b) dpbr_fab_inst.set({1'b1, r[i].w, r[i].a,
        r[i].d[8:0]});
      else {enA, weA, addrA, dinA} <= {1'b1, r[i].w, r[i].a, r[i].d};
      @(posedge clk) enA <= 0;
      dpbr_fab_inst.set({2'b0, r[i].a, ~r[i].d[8:0]});
      #1 if (!r[i].w)
        chk(r[i].d, r[i].b ? 36'(doutB_r) : doutA_r);
    end
    $display("table end");
    @(posedge clk) {enA, weA, addrA, dinA} <= {2'b11, 14'h3, 36'ha_5a5a_0f0f};
    @(posedge clk) weA <= 0;
    @(posedge clk) enA <= 0;
    #1 chk(36'ha_5a5a_0f0f, doutA_r);
    repeat (2) @(posedge clk);
    #1 chk(36'ha_5a5a_0f0f, doutA_r);
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    #1 chk(36'h0, doutA_r | 36'(doutB_r));
    $display("edge end");
    close_out();
  end
endmodule
